// ==== hw/dac_drv_regs.sv ====
/*
 * dac output driver control registers, page 0 offsets 36..40.
 * assumes a host-side control bus front end on the same clock that
 * presents one-cycle write strobes and combinational read address.
 */
// Summary of operation
// - bit 7 powers left dac up
// - bit 6 powers right dac up
// - left common terminal mode, 11 reserved
// - reserved nibbles store and read zero
// - high-power bits 7..6 read zero
// - right common terminal five modes decoded
// - bit 2 enables short protection, all drivers
// - bit 1 selects protection behaviour
// - high-power bit 0 reads zero
// - register 39 reads zero, ignores writes
// - common-mode level 1.35 to 1.8 V
// - soft-step rate, 11 reserved
`timescale 1ns/1ps
`include "dac_drv_cfg.svh"
module dac_drv_regs (
	// clock and reset
	input  wire logic                        mclk,
	input  wire logic                        rst,
	// register port
	input  wire logic [6:0]                  reg_addr,
	input  wire logic                        reg_wr,
	input  wire logic [7:0]                  reg_wdata,
	output logic      [7:0]                  reg_rdata,
	// adc flags shown at offset 36
	input  wire logic [7:0]                  adc_flags,
	// dac power
	output logic                             left_dac_on,
	output logic                             right_dac_on,
	// driver configuration
	output dac_drv_pkg::lcom_mode_type       left_common_terminal_mode,
	output dac_drv_pkg::rcom_mode_type       right_common_terminal_mode,
	output logic                             right_cm_feedback,
	// short-circuit protection
	output logic                             scp_enable,
	output logic                             scp_limit_current,
	output logic                             scp_auto_power_down,
	// output stage
	output dac_drv_pkg::cm_level_type        common_mode_level,
	output logic                             step_enable,
	output logic                             step_every_two
);
	import dac_drv_pkg::*;

	logic [7:0]    dac_power;   // offset 37 storage
	logic [7:0]    hp_drv_ctrl; // offset 38 storage
	logic [7:0]    out_stage;   // offset 40 storage
	logic [7:0]    wmask;       // writable bits of addressed reg
	logic [7:0]    fdata;       // filtered write data
	step_rate_type step_rate;   // soft-step code held at offset 40

	// writable mask decode for the addressed register
	function automatic logic [7:0] mask_of(input logic [6:0] a);
		if (a == `ADDR_DAC_POWER) begin
			mask_of = `DPWR_WMASK;
		end else if (a == `ADDR_HP_DRV_CTRL) begin
			mask_of = `HPC_WMASK;
		end else if (a == `ADDR_OUT_STAGE) begin
			mask_of = `OST_WMASK;
		end else begin
			mask_of = 8'h00; // flags and reserved slot take nothing
		end
	endfunction

	assign wmask = mask_of(reg_addr);

	// strip reserved bits before storing
	reg_field_guard guard (
		.wdata (reg_wdata),
		.wmask (wmask),
		.fdata (fdata)
	);

	// dac power and left terminal register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dac_power <= `RST_DAC_POWER;
		end else if (reg_wr && reg_addr == `ADDR_DAC_POWER) begin
			dac_power <= fdata;
		end
	end

	// high-power driver control register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hp_drv_ctrl <= `RST_HP_DRV_CTRL;
		end else if (reg_wr && reg_addr == `ADDR_HP_DRV_CTRL) begin
			hp_drv_ctrl <= fdata;
		end
	end

	// output stage register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			out_stage <= `RST_OUT_STAGE;
		end else if (reg_wr && reg_addr == `ADDR_OUT_STAGE) begin
			out_stage <= fdata;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		if (reg_addr == `ADDR_ADC_FLAG) begin
			reg_rdata = adc_flags;
		end else if (reg_addr == `ADDR_DAC_POWER) begin
			reg_rdata = dac_power;
		end else if (reg_addr == `ADDR_HP_DRV_CTRL) begin
			reg_rdata = hp_drv_ctrl;
		end else if (reg_addr == `ADDR_RESERVED) begin
			reg_rdata = `RST_RESERVED;
		end else if (reg_addr == `ADDR_OUT_STAGE) begin
			reg_rdata = out_stage;
		end else begin
			reg_rdata = 8'h00;
		end
	end

	assign left_dac_on  = dac_power[`DPWR_LEFT_BIT];
	assign right_dac_on = dac_power[`DPWR_RIGHT_BIT];

	assign left_common_terminal_mode =
		lcom_mode_type'(dac_power[`DPWR_LCOM_HI:`DPWR_LCOM_LO]);

	assign right_common_terminal_mode =
		rcom_mode_type'(hp_drv_ctrl[`HPC_RCOM_HI:`HPC_RCOM_LO]);

	// external feedback puts right terminal at common mode
	assign right_cm_feedback = (right_common_terminal_mode == RCOM_EXT_FB);

	// one enable for every high-power driver
	assign scp_enable = hp_drv_ctrl[`HPC_SCP_EN_BIT];

	assign scp_limit_current   = scp_enable &
	                             ~hp_drv_ctrl[`HPC_SCP_MODE_BIT];
	assign scp_auto_power_down = scp_enable &
	                             hp_drv_ctrl[`HPC_SCP_MODE_BIT];

	assign common_mode_level =
		cm_level_type'(out_stage[`OST_CM_HI:`OST_CM_LO]);

	// soft-step decode; reserved 11 treated as disabled
	assign step_rate      =
		step_rate_type'(out_stage[`OST_STEP_HI:`OST_STEP_LO]);
	assign step_enable    = (step_rate == STEP_EVERY_FS) ||
	                        (step_rate == STEP_EVERY_2FS);
	assign step_every_two = (step_rate == STEP_EVERY_2FS);

	a_dpwr_rsvd_zero: assert property (@(posedge mclk)
		disable iff (rst) (dac_power & ~`DPWR_WMASK) == 8'h00)
		else $error("dac power low nibble set");
	a_hpc_rsvd_zero: assert property (@(posedge mclk)
		disable iff (rst) (hp_drv_ctrl & ~`HPC_WMASK) == 8'h00)
		else $error("driver ctrl reserved bits set");
	a_ost_rsvd_zero: assert property (@(posedge mclk)
		disable iff (rst) (out_stage & ~`OST_WMASK) == 8'h00)
		else $error("output stage reserved set");
	a_left_power_wr: assert property (@(posedge mclk)
		disable iff (rst) reg_wr && reg_addr == `ADDR_DAC_POWER |=>
		left_dac_on == $past(reg_wdata[`DPWR_LEFT_BIT]))
		else $error("left dac power not written");
	a_right_power_wr: assert property (@(posedge mclk)
		disable iff (rst) reg_wr && reg_addr == `ADDR_DAC_POWER |=>
		right_dac_on == $past(reg_wdata[`DPWR_RIGHT_BIT]))
		else $error("right dac power not written");
	a_left_mode_wr: assert property (@(posedge mclk)
		disable iff (rst) reg_wr && reg_addr == `ADDR_DAC_POWER |=>
		left_common_terminal_mode ==
		$past(reg_wdata[`DPWR_LCOM_HI:`DPWR_LCOM_LO]))
		else $error("left terminal mode not written");
	a_scp_mode_excl: assert property (@(posedge mclk)
		disable iff (rst) !(scp_limit_current && scp_auto_power_down) &&
		(scp_enable == (scp_limit_current | scp_auto_power_down)))
		else $error("protection mode decode wrong");
	a_scp_mode_wr: assert property (@(posedge mclk)
		disable iff (rst) reg_wr && reg_addr == `ADDR_HP_DRV_CTRL |=>
		scp_auto_power_down == ($past(reg_wdata[`HPC_SCP_EN_BIT]) &&
		$past(reg_wdata[`HPC_SCP_MODE_BIT])))
		else $error("protection mode not written");
	a_rsvd_slot_zero: assert property (@(posedge mclk)
		disable iff (rst) reg_addr == `ADDR_RESERVED |-> reg_rdata == 8'h00)
		else $error("reserved register not zero");
	a_rsvd_slot_wr: assert property (@(posedge mclk)
		disable iff (rst) reg_wr && reg_addr == `ADDR_RESERVED |=>
		$stable(dac_power) && $stable(hp_drv_ctrl) &&
		$stable(out_stage))
		else $error("reserved register write stored");
	a_scp_en_wr: assert property (@(posedge mclk)
		disable iff (rst) reg_wr && reg_addr == `ADDR_HP_DRV_CTRL |=>
		scp_enable == $past(reg_wdata[`HPC_SCP_EN_BIT]))
		else $error("protection enable not written");
	a_cm_level_wr: assert property (@(posedge mclk)
		disable iff (rst) reg_wr && reg_addr == `ADDR_OUT_STAGE |=>
		common_mode_level == $past(reg_wdata[`OST_CM_HI:`OST_CM_LO]))
		else $error("common mode level not written");
	a_step_two_wr: assert property (@(posedge mclk)
		disable iff (rst) reg_wr && reg_addr == `ADDR_OUT_STAGE |=>
		step_every_two == ($past(reg_wdata[`OST_STEP_HI:`OST_STEP_LO])
		== STEP_EVERY_2FS))
		else $error("soft-step rate not written");
	// right mode only moves on a write
	a_rcom_hold: assert property (@(posedge mclk)
		disable iff (rst) !(reg_wr && reg_addr == `ADDR_HP_DRV_CTRL) |=>
		$stable(right_common_terminal_mode))
		else $error("right terminal mode changed without write");

	// main scenarios worth seeing at least once
	c_both_dacs_on: cover property (@(posedge mclk) disable iff (rst)
		left_dac_on && right_dac_on);
	c_rsvd_write: cover property (@(posedge mclk) disable iff (rst)
		reg_wr && reg_addr == `ADDR_RESERVED);
	c_auto_down: cover property (@(posedge mclk) disable iff (rst)
		scp_auto_power_down);
	c_ext_fb: cover property (@(posedge mclk) disable iff (rst)
		right_cm_feedback);
	c_step_two: cover property (@(posedge mclk) disable iff (rst)
		step_every_two);
endmodule

// ==== hw/dac_drv_cfg.svh ====
/*
 * constants for the dac output driver control register bank:
 * offsets, field positions, reset values.
 * assumes an 8-bit register port with 7-bit page-0 addresses.
 */
`ifndef DAC_DRV_CFG_SVH
`define DAC_DRV_CFG_SVH

// register offsets (page 0)
`define ADDR_ADC_FLAG      7'h24
`define ADDR_DAC_POWER     7'h25
`define ADDR_HP_DRV_CTRL   7'h26
`define ADDR_RESERVED      7'h27
`define ADDR_OUT_STAGE     7'h28

// dac power register fields
`define DPWR_LEFT_BIT      7
`define DPWR_RIGHT_BIT     6
`define DPWR_LCOM_HI       5
`define DPWR_LCOM_LO       4
`define DPWR_WMASK         8'hf0

// high-power driver control fields
`define HPC_RCOM_HI        5
`define HPC_RCOM_LO        3
`define HPC_SCP_EN_BIT     2
`define HPC_SCP_MODE_BIT   1
`define HPC_WMASK          8'h3e

// output stage fields
`define OST_CM_HI          7
`define OST_CM_LO          6
`define OST_STEP_HI        1
`define OST_STEP_LO        0
`define OST_WMASK          8'hc3

// reset values
`define RST_DAC_POWER      8'h00
`define RST_HP_DRV_CTRL    8'h00
`define RST_OUT_STAGE      8'h00
`define RST_RESERVED       8'h00

`endif

// ==== hw/dac_drv_pkg.sv ====
/*
 * types for the dac output driver control register bank.
 * assumes nothing beyond the cfg header for numbers.
 */
package dac_drv_pkg;
	// left common terminal configuration
	typedef enum logic [1:0] {
		LCOM_DIFF,
		LCOM_CONST_CM,
		LCOM_SINGLE,
		LCOM_RSVD
	} lcom_mode_type;
	// right common terminal configuration
	typedef enum logic [2:0] {
		RCOM_DIFF,
		RCOM_CONST_CM,
		RCOM_SINGLE,
		RCOM_DIFF_LCOM,
		RCOM_EXT_FB,
		RCOM_RSVD5,
		RCOM_RSVD6,
		RCOM_RSVD7
	} rcom_mode_type;
	// output common-mode level 1.35/1.5/1.65/1.8 V
	typedef enum logic [1:0] {
		CM_1V35,
		CM_1V50,
		CM_1V65,
		CM_1V80
	} cm_level_type;
	// soft-stepping rate
	typedef enum logic [1:0] {
		STEP_EVERY_FS,
		STEP_EVERY_2FS,
		STEP_OFF,
		STEP_RSVD
	} step_rate_type;
endpackage

// ==== hw/reg_field_guard.sv ====
/*
 * write filter for one 8-bit register: keeps only writable bits,
 * forces reserved bits to zero.
 * assumes the caller supplies the writable-bit mask.
 */
`timescale 1ns/1ps
module reg_field_guard (
	// data in
	input  wire logic [7:0] wdata,
	input  wire logic [7:0] wmask,
	// filtered data
	output logic      [7:0] fdata
);
	// reserved bits never store, so they always read zero
	assign fdata = wdata & wmask;
endmodule

// ==== tb/host_ctrl_model.sv ====
/*
 * host model for the driver control registers: writes and reads.
 * assumes combinational read data and one-cycle write strobes.
 */
`timescale 1ns/1ps
module host_ctrl_model (
	// clock and read data
	input  wire logic       mclk,
	input  wire logic [7:0] reg_rdata,
	// register port
	output logic      [6:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata
);
	// idle bus at time zero
	initial begin
		reg_addr  = 7'h00;
		reg_wr    = 1'b0;
		reg_wdata = 8'h00;
	end
	// one write at a falling edge; raw skips the host's own limits
	task automatic put(input logic [6:0] a, input logic [7:0] d,
		input bit raw, output logic [7:0] v);
		logic [1:0] r;
		r = d[4:3] & {2{~d[5]}};
		v = d;
		if (!raw) begin
			if (a == 7'h25) v = {d[7:6], d[5] & ~d[4], d[4], 4'h0};
			if (a == 7'h26) v = {2'b00, d[5], r, d[2:1], 1'b0};
			if (a == 7'h28) v = {d[7:6], 4'h0, d[1] & ~d[0], d[0]};
		end
		@(negedge mclk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= raw || a != 7'h27;
	endtask
	// read: address at a falling edge, data taken at the next rising one
	task automatic rd(input logic [6:0] a, output logic [7:0] q);
		@(negedge mclk);
		reg_addr <= a;
		reg_wr   <= 1'b0;
		@(posedge mclk);
		q = reg_rdata;
	endtask
endmodule

// ==== tb/dac_drv_regs_tb.sv ====
/*
 * self-checking bench for the dac output driver control registers.
 * assumes the host model drives the port on falling edges.
 */
`timescale 1ns/1ps
module dac_drv_regs_tb;
	import dac_drv_pkg::*;
	logic          mclk, rst, wr, ldac, rdac, fb, scp, lim, apd, sen, s2;
	logic [6:0]    addr;
	logic [7:0]    wdata, rdata, adc_flags;
	lcom_mode_type lcm;
	rcom_mode_type rcm;
	cm_level_type  cml;
	logic [7:0]    sh [3];          // shadow of 0x25, 0x26, 0x28
	logic [6:0]    addrs [6] = '{7'h24, 7'h25, 7'h26, 7'h27, 7'h28, 7'h7f};
	int            n_errors, samples_checked;
	dac_drv_regs dac_drv_regs_inst (.mclk(mclk), .rst(rst),
		.reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
		.reg_rdata(rdata), .adc_flags(adc_flags), .left_dac_on(ldac),
		.right_dac_on(rdac), .left_common_terminal_mode(lcm),
		.right_common_terminal_mode(rcm), .right_cm_feedback(fb),
		.scp_enable(scp), .scp_limit_current(lim),
		.scp_auto_power_down(apd), .common_mode_level(cml),
		.step_enable(sen), .step_every_two(s2));
	host_ctrl_model host_ctrl_model_inst (.mclk(mclk), .reg_rdata(rdata),
		.reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata));
	// 250 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// read value per offset; reserved bits always zero
	function automatic logic [7:0] exp_rd(input logic [6:0] a);
		case (a)
			7'h24: exp_rd = adc_flags;
			7'h25: exp_rd = sh[0] & 8'hf0;
			7'h26: exp_rd = sh[1] & 8'h3e;
			7'h28: exp_rd = sh[2] & 8'hc3;
			default: exp_rd = 8'h00;
		endcase
	endfunction
	// read every offset, then every output
	task automatic check_all();
		logic [7:0] q;
		for (int i = 0; i < 6; i++) begin
			host_ctrl_model_inst.rd(addrs[i], q);
			check(q, exp_rd(addrs[i]));
		end
		check({7'h0, ldac}, {7'h0, sh[0][7]});
		check({7'h0, rdac}, {7'h0, sh[0][6]});
		check({6'h0, lcm}, {6'h0, sh[0][5:4]});
		check({5'h0, rcm}, {5'h0, sh[1][5:3]});
		check({7'h0, fb}, {7'h0, sh[1][5:3] == 3'b100});
		check({7'h0, scp}, {7'h0, sh[1][2]});
		check({7'h0, lim}, {7'h0, sh[1][2] & ~sh[1][1]});
		check({7'h0, apd}, {7'h0, sh[1][2] & sh[1][1]});
		check({6'h0, cml}, {6'h0, sh[2][7:6]});
		check({7'h0, sen}, {7'h0, sh[2][1:0] < 2'd2});
		check({7'h0, s2}, {7'h0, sh[2][1:0] == 2'b01});
	endtask
	// write through the host, shadow what was sent
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d,
		input bit raw);
		logic [7:0] v;
		host_ctrl_model_inst.put(a, d, raw, v);
		if (a == 7'h25) sh[0] = v;
		if (a == 7'h26) sh[1] = v;
		if (a == 7'h28) sh[2] = v;
	endtask
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// watchdog: the run needs well under 1000 cycles
	initial begin
		repeat (4000) @(posedge mclk);
		n_errors++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'h17ec9238));
		rst = 1'b1;
		adc_flags = 8'h5a;
		sh = '{8'h00, 8'h00, 8'h00};
		repeat (10) @(negedge mclk);
		rst = 1'b0;
		check_all();
		// every code of every field, reserved ones too, raw
		for (int i = 0; i < 8; i++) begin
			wr_reg(7'h26, {2'b11, i[2:0], i[1:0], 1'b1}, 1'b1);
			wr_reg(7'h25, {i[1:0], i[1:0], 4'hf}, 1'b1);
			wr_reg(7'h28, {i[1:0], 4'hf, i[1:0]}, 1'b1);
			check_all();
		end
		// random legal traffic, flags moving meanwhile
		repeat (30) begin
			@(negedge mclk);
			adc_flags = 8'($urandom);
			wr_reg(addrs[$urandom_range(1, 4)], 8'($urandom), 1'b0);
			check_all();
		end
		// all ones, back to back; flags, reserved and unmapped ignored
		wr_reg(7'h24, 8'hff, 1'b1);
		wr_reg(7'h7f, 8'hff, 1'b1);
		wr_reg(7'h25, 8'hff, 1'b1);
		wr_reg(7'h26, 8'hff, 1'b1);
		wr_reg(7'h27, 8'hff, 1'b1);
		wr_reg(7'h28, 8'hff, 1'b1);
		check_all();
		// reset in mid-run clears every register
		@(negedge mclk);
		rst = 1'b1;
		sh = '{8'h00, 8'h00, 8'h00};
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		check_all();
		tally_and_finish();
	end
endmodule
